// ==== shared/fad_pkg.sv ====
// Constants and types shared by the flag and add/subtract decode block
package fad_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_ACC_HIGH = 8'h04;
   localparam logic [7:0] ADDR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;

   // Register index returned by the address decoder
   localparam logic [2:0] IDX_INSTR = 3'h0;
   localparam logic [2:0] IDX_ACC_HIGH = 3'h1;
   localparam logic [2:0] IDX_FLAGS = 3'h2;
   localparam logic [2:0] IDX_STATUS = 3'h3;
   localparam logic [2:0] IDX_NONE = 3'h7;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Whole opcodes
   localparam logic [7:0] OPC_LOAD_FLAGS = 8'h9E;
   localparam logic [7:0] OPC_SET_CARRY = 8'hF9;
   localparam logic [7:0] OPC_SET_DIRECTION = 8'hFD;
   localparam logic [7:0] OPC_SET_INT_ENABLE = 8'hFB;

   // Opcode patterns with low d/s/w or register bits stripped
   localparam logic [5:0] PAT_ADD_RM = 6'h00;
   localparam logic [5:0] PAT_ADC_RM = 6'h04;
   localparam logic [5:0] PAT_SUB_RM = 6'h0A;
   localparam logic [5:0] PAT_IMM_GROUP = 6'h20;
   localparam logic [6:0] PAT_ADD_ACC = 7'h02;
   localparam logic [6:0] PAT_ADC_ACC = 7'h0A;
   localparam logic [6:0] PAT_INC_RM = 7'h7F;
   localparam logic [4:0] PAT_INC_SHORT = 5'h08;

   // Middle field of the mod/reg/rm byte and the register mode
   localparam logic [2:0] EXT_ADD = 3'h0;
   localparam logic [2:0] EXT_ADC = 3'h2;
   localparam logic [2:0] EXT_INC = 3'h0;
   localparam logic [1:0] MOD_REGISTER = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Clock counts
   localparam logic [3:0] CLK_LOAD_FLAGS = 4'h3;
   localparam logic [3:0] CLK_FLAG_SET = 4'h2;
   localparam logic [3:0] CLK_INT_ENABLE = 4'h8;
   localparam logic [3:0] CLK_REG = 4'h2;
   localparam logic [3:0] CLK_MEM_DEST = 4'h7;
   localparam logic [3:0] CLK_MEM_SRC = 4'h6;
   localparam logic [3:0] CLK_INC_MEM = 4'h6;
   localparam logic [3:0] CLK_LAST = 4'h1;

   ////////////////////////////////////////////////////////////////////////
   // Flag layout
   localparam logic [7:0] FLAGS_ACC_MASK = 8'hD5;
   localparam logic [7:0] FLAGS_FIXED = 8'h02;
   localparam int FLAG_CARRY_BIT = 0;
   localparam int FLAG_INT_BIT = 9;
   localparam int FLAG_DIR_BIT = 10;

   // Status write-one-to-clear bits
   localparam int ST_DONE_BIT = 1;
   localparam int ST_UNKNOWN_BIT = 2;
   localparam int ST_REFUSED_BIT = 3;

   typedef enum logic [3:0] {
      FAD_OP_NONE,
      FAD_OP_LOAD_FLAGS,
      FAD_OP_SET_CARRY,
      FAD_OP_SET_DIRECTION,
      FAD_OP_SET_INT_ENABLE,
      FAD_OP_ADD,
      FAD_OP_ADC,
      FAD_OP_INC,
      FAD_OP_SUB
   } fad_op_t;

endpackage : fad_pkg

// ==== hw/fad_classify.sv ====
// Combinational opcode classifier for the flag and add/subtract forms
`timescale 1ns/1ps
module fad_classify (
   input wire logic [7:0] opcode_in,
   input wire logic [7:0] modrm_in,
   output fad_pkg::fad_op_t op_out,
   output logic [3:0] clocks_out,
   output logic mem_out,
   output logic dir_out,
   output logic wide_out,
   output logic sext_out,
   output logic imm_out,
   output logic [2:0] reg_out
);
   logic is_mem;
   logic [2:0] mid;

   always_comb begin
      is_mem = (modrm_in[7:6] != fad_pkg::MOD_REGISTER);
      mid = modrm_in[5:3];
      op_out = fad_pkg::FAD_OP_NONE;
      clocks_out = fad_pkg::CLK_LAST;
      mem_out = 1'b0;
      dir_out = opcode_in[1];
      wide_out = opcode_in[0];
      sext_out = 1'b0;
      imm_out = 1'b0;
      reg_out = mid;
      if (opcode_in == fad_pkg::OPC_LOAD_FLAGS) begin
         op_out = fad_pkg::FAD_OP_LOAD_FLAGS;
         clocks_out = fad_pkg::CLK_LOAD_FLAGS;
      end else if (opcode_in == fad_pkg::OPC_SET_CARRY) begin
         op_out = fad_pkg::FAD_OP_SET_CARRY;
         clocks_out = fad_pkg::CLK_FLAG_SET;
      end else if (opcode_in == fad_pkg::OPC_SET_DIRECTION) begin
         op_out = fad_pkg::FAD_OP_SET_DIRECTION;
         clocks_out = fad_pkg::CLK_FLAG_SET;
      end else if (opcode_in == fad_pkg::OPC_SET_INT_ENABLE) begin
         op_out = fad_pkg::FAD_OP_SET_INT_ENABLE;
         clocks_out = fad_pkg::CLK_INT_ENABLE;
      end else if (opcode_in[7:2] == fad_pkg::PAT_ADD_RM ||
                   opcode_in[7:2] == fad_pkg::PAT_ADC_RM) begin
         op_out = (opcode_in[7:2] == fad_pkg::PAT_ADD_RM) ? fad_pkg::FAD_OP_ADD :
                  fad_pkg::FAD_OP_ADC;
         mem_out = is_mem;
         // lower for register
         // Direction picks memory as destination or as source
         clocks_out = !is_mem ? fad_pkg::CLK_REG :
                      (opcode_in[1] ? fad_pkg::CLK_MEM_SRC : fad_pkg::CLK_MEM_DEST);
      end else if (opcode_in[7:2] == fad_pkg::PAT_IMM_GROUP &&
                   (mid == fad_pkg::EXT_ADD || mid == fad_pkg::EXT_ADC)) begin
         op_out = (mid == fad_pkg::EXT_ADD) ? fad_pkg::FAD_OP_ADD : fad_pkg::FAD_OP_ADC;
         mem_out = is_mem;
         imm_out = 1'b1;
         dir_out = 1'b0;
         sext_out = opcode_in[1];
         clocks_out = is_mem ? fad_pkg::CLK_MEM_DEST : fad_pkg::CLK_REG;
      end else if (opcode_in[7:1] == fad_pkg::PAT_ADD_ACC ||
                   opcode_in[7:1] == fad_pkg::PAT_ADC_ACC) begin
         op_out = (opcode_in[7:1] == fad_pkg::PAT_ADD_ACC) ? fad_pkg::FAD_OP_ADD :
                  fad_pkg::FAD_OP_ADC;
         imm_out = 1'b1;
         dir_out = 1'b0;
         reg_out = 3'h0;
         clocks_out = fad_pkg::CLK_REG;
      end else if (opcode_in[7:1] == fad_pkg::PAT_INC_RM && mid == fad_pkg::EXT_INC) begin
         op_out = fad_pkg::FAD_OP_INC;
         mem_out = is_mem;
         dir_out = 1'b0;
         reg_out = modrm_in[2:0];
         clocks_out = is_mem ? fad_pkg::CLK_INC_MEM : fad_pkg::CLK_REG;
      end else if (opcode_in[7:3] == fad_pkg::PAT_INC_SHORT) begin
         op_out = fad_pkg::FAD_OP_INC;
         dir_out = 1'b0;
         wide_out = 1'b1;
         reg_out = opcode_in[2:0];
         clocks_out = fad_pkg::CLK_REG;
      end else if (opcode_in[7:2] == fad_pkg::PAT_SUB_RM && !is_mem) begin
         // Memory forms of subtract are not handled here
         op_out = fad_pkg::FAD_OP_SUB;
         clocks_out = fad_pkg::CLK_REG;
      end
   end
endmodule : fad_classify

// ==== hw/fad_top.sv ====
// Flag and add/subtract decode block with AXI4-Lite register access
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module fad_top (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic busy_out,
   output logic [7:0] flags_out,
   output logic direction_out,
   output logic int_enable_out
);

   typedef enum logic {FAD_IDLE, FAD_RUN} fad_fsm_t;

   typedef struct packed {
      fad_fsm_t st;
      logic busy;
      logic [3:0] cnt;
      logic [3:0] elapsed;
      fad_pkg::fad_op_t op;
      logic [3:0] total;
      logic mem;
      logic dir;
      logic wide;
      logic sext;
      logic imm;
      logic [2:0] regf;
      logic [7:0] opcode;
      logic [7:0] flags;
      logic ie;
      logic df;
      logic [7:0] acc_hi;
      logic done;
      logic unknown;
      logic refused;
      logic aw_held;
      logic [7:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fad_core_t;

   fad_core_t s;
   fad_core_t next_s;

   fad_pkg::fad_op_t dec_op;
   logic [3:0] dec_clocks;
   logic dec_mem;
   logic dec_dir;
   logic dec_wide;
   logic dec_sext;
   logic dec_imm;
   logic [2:0] dec_reg;

   ////////////////////////////////////////////////////////////////////////
   // Register index from a byte address; shared by both channels
   function automatic logic [2:0] reg_index(input logic [7:0] addr);
      logic [2:0] idx;
      idx = fad_pkg::IDX_NONE;
      if (addr[7:2] == fad_pkg::ADDR_INSTR[7:2]) begin
         idx = fad_pkg::IDX_INSTR;
      end else if (addr[7:2] == fad_pkg::ADDR_ACC_HIGH[7:2]) begin
         idx = fad_pkg::IDX_ACC_HIGH;
      end else if (addr[7:2] == fad_pkg::ADDR_FLAGS[7:2]) begin
         idx = fad_pkg::IDX_FLAGS;
      end else if (addr[7:2] == fad_pkg::ADDR_STATUS[7:2]) begin
         idx = fad_pkg::IDX_STATUS;
      end
      return idx;
   endfunction : reg_index

   // Byte-lane merge under the write strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////
   // Decoder sees the held write data, so starting costs no extra cycle
   fad_classify u_classify (
      .opcode_in(s.wdata[7:0]),
      .modrm_in(s.wdata[15:8]),
      .op_out(dec_op),
      .clocks_out(dec_clocks),
      .mem_out(dec_mem),
      .dir_out(dec_dir),
      .wide_out(dec_wide),
      .sext_out(dec_sext),
      .imm_out(dec_imm),
      .reg_out(dec_reg)
   );

   ////////////////////////////////////////////////////////////////////////
   // Flag bits above the low byte
   localparam int FAD_INT = fad_pkg::FLAG_INT_BIT;
   localparam int FAD_DIR = fad_pkg::FLAG_DIR_BIT;

   always_comb begin
      logic [31:0] wv;
      logic [31:0] fl;
      logic [2:0] widx;
      logic [2:0] ridx;
      next_s = s;
      wv = 32'h0000_0000;
      fl = 32'h0000_0000;
      widx = reg_index(s.awaddr);
      ridx = reg_index(s_axi_araddr_in);

      if (s.awready && s_axi_awvalid_in) begin
         next_s.aw_held = 1'b1;
         next_s.awaddr = s_axi_awaddr_in;
      end
      if (s.wready && s_axi_wvalid_in) begin
         next_s.w_held = 1'b1;
         next_s.wdata = s_axi_wdata_in;
         next_s.wstrb = s_axi_wstrb_in;
      end
      if (s.bvalid && s_axi_bready_in) begin
         next_s.bvalid = 1'b0;
      end

      // Write executes once address and data are both held
      if (s.aw_held && s.w_held && !s.bvalid) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = fad_pkg::RESP_OKAY;
         if (widx == fad_pkg::IDX_INSTR) begin
            if (s.wstrb[0]) begin
               if (s.st == FAD_RUN) begin
                  // No queue: a start while busy is dropped and flagged
                  next_s.refused = 1'b1;
               end else if (dec_op == fad_pkg::FAD_OP_NONE) begin
                  next_s.unknown = 1'b1;
                  next_s.done = 1'b1;
                  next_s.opcode = s.wdata[7:0];
                  next_s.op = dec_op;
               end else begin
                  next_s.st = FAD_RUN;
                  next_s.opcode = s.wdata[7:0];
                  next_s.op = dec_op;
                  next_s.cnt = dec_clocks;
                  next_s.total = dec_clocks;
                  next_s.elapsed = 4'h0;
                  next_s.mem = dec_mem;
                  next_s.dir = dec_dir;
                  next_s.wide = dec_wide;
                  next_s.sext = dec_sext;
                  next_s.imm = dec_imm;
                  next_s.regf = dec_reg;
               end
            end
         end else if (widx == fad_pkg::IDX_ACC_HIGH) begin
            wv = merge({24'h00_0000, s.acc_hi}, s.wdata, s.wstrb);
            next_s.acc_hi = wv[7:0];
         end else if (widx == fad_pkg::IDX_FLAGS) begin
            fl = {21'h00_0000, s.df, s.ie, 1'b0, s.flags};
            wv = merge(fl, s.wdata, s.wstrb);
            next_s.flags = wv[7:0] | fad_pkg::FLAGS_FIXED;
            next_s.ie = wv[FAD_INT];
            next_s.df = wv[FAD_DIR];
         end else if (widx == fad_pkg::IDX_STATUS) begin
            if (s.wstrb[0] && s.wdata[fad_pkg::ST_DONE_BIT]) begin
               next_s.done = 1'b0;
            end
            if (s.wstrb[0] && s.wdata[fad_pkg::ST_UNKNOWN_BIT]) begin
               next_s.unknown = 1'b0;
            end
            if (s.wstrb[0] && s.wdata[fad_pkg::ST_REFUSED_BIT]) begin
               next_s.refused = 1'b0;
            end
         end else begin
            next_s.bresp = fad_pkg::RESP_SLVERR;
         end
      end

      // Execution countdown; finishing after the clear keeps set winning
      if (s.st == FAD_RUN) begin
         next_s.elapsed = s.elapsed + 4'h1;
         if (s.cnt == fad_pkg::CLK_LAST) begin
            next_s.st = FAD_IDLE;
            next_s.done = 1'b1;
            case (s.op)
               fad_pkg::FAD_OP_LOAD_FLAGS: begin
                  next_s.flags = (s.acc_hi & fad_pkg::FLAGS_ACC_MASK) | fad_pkg::FLAGS_FIXED;
               end
               fad_pkg::FAD_OP_SET_CARRY: begin
                  next_s.flags[fad_pkg::FLAG_CARRY_BIT] = 1'b1;
               end
               fad_pkg::FAD_OP_SET_DIRECTION: begin
                  next_s.df = 1'b1;
               end
               fad_pkg::FAD_OP_SET_INT_ENABLE: begin
                  next_s.ie = 1'b1;
               end
               default: begin
                  // Arithmetic forms only account for time here
                  next_s.ie = s.ie;
               end
            endcase
         end else begin
            next_s.cnt = s.cnt - 4'h1;
         end
      end

      if (s.rvalid && s_axi_rready_in) begin
         next_s.rvalid = 1'b0;
      end
      if (s.arready && s_axi_arvalid_in) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = fad_pkg::RESP_OKAY;
         if (ridx == fad_pkg::IDX_INSTR) begin
            next_s.rdata = {24'h00_0000, s.opcode};
         end else if (ridx == fad_pkg::IDX_ACC_HIGH) begin
            next_s.rdata = {24'h00_0000, s.acc_hi};
         end else if (ridx == fad_pkg::IDX_FLAGS) begin
            next_s.rdata = {21'h00_0000, s.df, s.ie, 1'b0, s.flags};
         end else if (ridx == fad_pkg::IDX_STATUS) begin
            next_s.rdata = {12'h000, s.regf, s.imm, s.sext, s.wide, s.dir, s.mem, s.total,
                            s.op, s.refused, s.unknown, s.done, s.busy};
         end else begin
            next_s.rdata = 32'h0000_0000;
            next_s.rresp = fad_pkg::RESP_SLVERR;
         end
      end

      next_s.busy = (next_s.st == FAD_RUN);
      next_s.awready = !next_s.aw_held && !next_s.bvalid;
      next_s.wready = !next_s.w_held && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '0;
         s.flags <= fad_pkg::FLAGS_FIXED;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready_out = s.awready;
   assign s_axi_wready_out = s.wready;
   assign s_axi_bresp_out = s.bresp;
   assign s_axi_bvalid_out = s.bvalid;
   assign s_axi_arready_out = s.arready;
   assign s_axi_rdata_out = s.rdata;
   assign s_axi_rresp_out = s.rresp;
   assign s_axi_rvalid_out = s.rvalid;
   assign busy_out = s.busy;
   assign flags_out = s.flags;
   assign direction_out = s.df;
   assign int_enable_out = s.ie;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   AST_LOAD_FLAGS: assert property ($rose(s.busy) && s.op == fad_pkg::FAD_OP_LOAD_FLAGS
      |-> s.busy[*3] ##1 (!s.busy && s.flags == ((s.acc_hi & fad_pkg::FLAGS_ACC_MASK)
      | fad_pkg::FLAGS_FIXED))) else $error("load flags timing or value wrong");
   AST_SET_CARRY: assert property ($rose(s.busy) && s.op == fad_pkg::FAD_OP_SET_CARRY
      |-> s.busy ##1 s.busy ##1 (!s.busy && s.flags[fad_pkg::FLAG_CARRY_BIT]))
      else $error("set carry timing wrong");
   AST_SET_DIRECTION: assert property ($rose(s.busy) && s.op == fad_pkg::FAD_OP_SET_DIRECTION
      |-> s.busy[*2] ##1 (!s.busy && s.df)) else $error("set direction timing wrong");
   AST_SET_INT: assert property ($rose(s.busy) && s.op == fad_pkg::FAD_OP_SET_INT_ENABLE
      |-> ##7 s.busy ##1 (!s.busy && s.ie)) else $error("set interrupt timing wrong");
   AST_RM_FORMS: assert property ($rose(s.busy) && !s.imm && (s.opcode[7:2] ==
      fad_pkg::PAT_ADD_RM || s.opcode[7:2] == fad_pkg::PAT_ADC_RM) |-> s.total ==
      (!s.mem ? fad_pkg::CLK_REG : (s.dir ? fad_pkg::CLK_MEM_SRC : fad_pkg::CLK_MEM_DEST)))
      else $error("add rm clock count wrong");
   AST_IMM_GROUP: assert property ($rose(s.busy) && s.opcode[7:2] == fad_pkg::PAT_IMM_GROUP
      |-> s.imm && s.total == (s.mem ? fad_pkg::CLK_MEM_DEST : fad_pkg::CLK_REG) &&
      s.sext == s.opcode[1]) else $error("immediate group decode wrong");
   AST_ACC_SHORT: assert property ($rose(s.busy) && (s.opcode[7:1] == fad_pkg::PAT_ADD_ACC
      || s.opcode[7:1] == fad_pkg::PAT_ADC_ACC) |-> s.busy[*2] ##1 !s.busy)
      else $error("accumulator short form timing wrong");
   AST_INC: assert property ($rose(s.busy) && s.op == fad_pkg::FAD_OP_INC |-> s.total ==
      (s.mem ? fad_pkg::CLK_INC_MEM : fad_pkg::CLK_REG)) else $error("increment count wrong");
   AST_SUB: assert property ($rose(s.busy) && s.op == fad_pkg::FAD_OP_SUB
      |-> !s.mem ##2 !s.busy) else $error("subtract timing wrong");
   AST_LENGTH: assert property ($fell(s.busy) |-> s.elapsed == s.total && s.done)
      else $error("busy length differs from clock count");
   AST_WIDTH: assert property ($rose(s.busy) && s.opcode[7:3] != fad_pkg::PAT_INC_SHORT
      && s.op != fad_pkg::FAD_OP_LOAD_FLAGS && s.op != fad_pkg::FAD_OP_SET_CARRY
      |-> s.wide == s.opcode[0]) else $error("width bit not followed");

   COV_LOAD_FLAGS: cover property ($fell(s.busy) && s.op == fad_pkg::FAD_OP_LOAD_FLAGS);
   COV_SET_INT: cover property ($fell(s.busy) && s.op == fad_pkg::FAD_OP_SET_INT_ENABLE);
   COV_ADD_MEM: cover property ($rose(s.busy) && s.op == fad_pkg::FAD_OP_ADD && s.mem);
   COV_REFUSED: cover property ($rose(s.refused));

endmodule : fad_top

// ==== verif/testbench.sv ====
// Self-checking bench for the flag and add/subtract decode block
`timescale 1ns/1ps
module testbench;
   logic core_clk_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
   logic s_axi_arvalid_in, s_axi_rready_in;
   logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, flags_out;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
   logic [3:0] s_axi_wstrb_in;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic s_axi_rvalid_out, busy_out, direction_out, int_enable_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
   logic [31:0] s;
   int fail_count = 0, checked = 0, bc = 0;
   fad_top dut (.core_clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
      .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
      .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
      .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
      .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .busy_out, .flags_out,
      .direction_out, .int_enable_out);
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk_in = 0;
      forever #10 core_clk_in = ~core_clk_in;
   end
   // Counts clock edges with busy high, so latency is judged without guessing start edge
   always @(posedge core_clk_in) if (busy_out === 1'b1) bc++;
   task automatic chk(input logic [31:0] g, e, input string m);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      logic aw, wd, b;
      {aw, wd, b} = 3'h7;
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
      while (aw | wd | b) begin
         @(posedge core_clk_in);
         if (aw && s_axi_awready_out) begin aw = 0; s_axi_awvalid_in <= 1'b0; end
         if (wd && s_axi_wready_out) begin wd = 0; s_axi_wvalid_in <= 1'b0; end
         if (b && s_axi_bvalid_out) begin
            b = 0;
            rs = s_axi_bresp_out;
            s_axi_bready_in <= 1'b0;
         end
      end
      // One edge between transfers, so no signal is driven twice a step
      @(posedge core_clk_in);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      s_axi_araddr_in <= a;
      {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
      do @(posedge core_clk_in); while (s_axi_arready_out !== 1'b1);
      s_axi_arvalid_in <= 1'b0;
      while (s_axi_rvalid_out !== 1'b1) @(posedge core_clk_in);
      d = s_axi_rdata_out;
      rs = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
      @(posedge core_clk_in);
   endtask : rd
   // Runs one opcode and judges busy length and decoded status
   task automatic run(input logic [7:0] o, m, input logic [3:0] n, op, input logic mem);
      bc = 0;
      wr(8'h00, {16'h0000, m, o}, r);
      repeat (12) @(posedge core_clk_in);
      chk(bc, {28'h0, n}, "busy cycles");
      rd(8'h0C, s, r);
      if (n == 4'h0) chk({31'h0, s[2]}, 32'h1, "unknown");
      else chk({23'h0, s[12:4]}, {23'h0, mem, n, op}, "status");
      wr(8'h0C, 32'h0000000E, r);
   endtask : run
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(8'h08, s, r);
      chk(s, 32'h00000002, "flags reset");
      rd(8'h10, s, r);
      chk({s[31:2], r}, {30'h0, 2'h2}, "unmapped read");
      wr(8'h14, 32'h0000FFFF, r);
      chk({30'h0, r}, 32'h2, "unmapped write");
      $display("test regs done");
   endtask : t_regs
   task automatic t_flags;
      wr(8'h04, 32'h0000003C, r);
      run(8'h9E, 8'h00, 4'h3, 4'h1, 1'b0);
      chk({24'h0, flags_out}, 32'h16, "acc high to flags");
      run(8'hF9, 8'h00, 4'h2, 4'h2, 1'b0);
      chk({24'h0, flags_out}, 32'h17, "carry set");
      run(8'hFD, 8'h00, 4'h2, 4'h3, 1'b0);
      chk({31'h0, direction_out}, 32'h1, "direction set");
      run(8'hFB, 8'h00, 4'h8, 4'h4, 1'b0);
      chk({31'h0, int_enable_out}, 32'h1, "int enable set");
      $display("test flags done");
   endtask : t_flags
   task automatic t_add;
      run(8'h01, 8'hC0, 4'h2, 4'h5, 1'b0);
      run(8'h01, 8'h00, 4'h7, 4'h5, 1'b1);
      run(8'h03, 8'h05, 4'h6, 4'h5, 1'b1);
      run(8'h81, 8'hC0, 4'h2, 4'h5, 1'b0);
      run(8'h81, 8'h00, 4'h7, 4'h5, 1'b1);
      run(8'h05, 8'h00, 4'h2, 4'h5, 1'b0);
      chk({24'h0, flags_out}, 32'h17, "flags kept");
      $display("test add done");
   endtask : t_add
   task automatic t_adc;
      run(8'h13, 8'hC1, 4'h2, 4'h6, 1'b0);
      run(8'h11, 8'h00, 4'h7, 4'h6, 1'b1);
      run(8'h13, 8'h00, 4'h6, 4'h6, 1'b1);
      run(8'h83, 8'hD0, 4'h2, 4'h6, 1'b0);
      run(8'h83, 8'h10, 4'h7, 4'h6, 1'b1);
      run(8'h15, 8'h00, 4'h2, 4'h6, 1'b0);
      $display("test adc done");
   endtask : t_adc
   task automatic t_inc_sub;
      run(8'hFF, 8'hC3, 4'h2, 4'h7, 1'b0);
      run(8'hFE, 8'h00, 4'h6, 4'h7, 1'b1);
      run(8'h47, 8'h00, 4'h2, 4'h7, 1'b0);
      run(8'h2B, 8'hC0, 4'h2, 4'h8, 1'b0);
      run(8'h81, 8'hE8, 4'h0, 4'h0, 1'b0);
      $display("test inc sub done");
   endtask : t_inc_sub
   task automatic t_steer;
      run(8'h03, 8'hC0, 4'h2, 4'h5, 1'b0);
      chk({30'h0, s[14:13]}, 32'h3, "dir wide");
      run(8'h00, 8'hC0, 4'h2, 4'h5, 1'b0);
      chk({30'h0, s[14:13]}, 32'h0, "byte order");
      run(8'h83, 8'hC0, 4'h2, 4'h5, 1'b0);
      chk({28'h0, s[16:13]}, 32'hE, "sign extend");
      $display("test steer done");
   endtask : t_steer
   task automatic t_refuse;
      wr(8'h00, 32'h000000FB, r);
      wr(8'h00, 32'h000000F9, r);
      chk({30'h0, r}, 32'h0, "busy write resp");
      repeat (10) @(posedge core_clk_in);
      rd(8'h0C, s, r);
      chk({28'h0, s[7:4]}, 32'h4, "refused keeps op");
      chk({31'h0, s[3]}, 32'h1, "refused flag");
      $display("test refuse done");
   endtask : t_refuse
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial begin
      #200000;
      fail_count++;
      final_report;
   end
   initial begin
      {rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 4'h8;
      {s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = '0;
      s_axi_wdata_in = '0;
      s_axi_wstrb_in = 4'hF;
      repeat (4) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      t_regs;
      t_flags;
      t_add;
      t_adc;
      t_inc_sub;
      t_steer;
      t_refuse;
      final_report;
   end
endmodule : testbench
